// ---- hdl/sac_pkg.sv ----
// Constants and types for the converter channel sequencer.
package sac_pkg;
	localparam int unsigned SYS_HZ     = 100_000_000;
	localparam int unsigned CCLK_MAX   = 18_000_000;
	localparam logic [7:0]  DIV_MIN    = 8'((SYS_HZ + CCLK_MAX - 1) / CCLK_MAX);
	localparam int unsigned BITS       = 12;
	localparam int unsigned CONV_MIN   = 18;
	localparam logic [7:0]  SAMP_MIN   = 8'(CONV_MIN - BITS);
	localparam int unsigned NCH        = 9;
	localparam logic [3:0]  TEMP_CH    = 4'h8;
	localparam int unsigned AW         = 8;
	localparam logic [7:0]  CTRL_OFF   = 8'h00;
	localparam logic [7:0]  CHEN_OFF   = 8'h04;
	localparam logic [7:0]  STAT_OFF   = 8'h08;
	localparam logic [7:0]  MASK_OFF   = 8'h0c;
	localparam logic [7:0]  LIM_OFF    = 8'h10;
	localparam logic [7:0]  DIV_OFF    = 8'h14;
	localparam logic [7:0]  SAMP_BASE  = 8'h40;
	localparam logic [7:0]  RES_BASE   = 8'h80;
	localparam logic [7:0]  REGION_M   = 8'hc0;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_CONT  = 1;
	localparam int unsigned CTRL_MAN   = 2;
	localparam int unsigned CTRL_MCH   = 4;
	localparam int unsigned CTRL_REF   = 8;
	localparam logic [9:0]  CTRL_RST   = 10'h000;
	localparam int unsigned ST_CONV    = 0;
	localparam int unsigned ST_OOR     = 1;
	localparam int unsigned ST_SCAN    = 2;
	localparam int unsigned ST_BUSY    = 8;
	localparam int unsigned ST_CUR     = 12;
	localparam logic [31:0] LIM_MASK   = 32'h0fff_0fff;
	localparam logic [31:0] LIM_RST    = 32'h0fff_0000;
	localparam logic [7:0]  DIV_RST    = 8'h06;
	localparam logic [7:0]  SAMP_RST   = 8'h06;
	localparam logic [11:0] DAC_MSB    = 12'h800;
	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_LOAD = 2'b01,
		SAC_PREP = 2'b11,
		SAC_CONV = 2'b10
	} sac_state_t;
endpackage

// ---- hdl/sac_mem.sv ----
// Small register file with one write port and two registered read ports.
`timescale 1ns/1ps
module sac_mem #(
	parameter int unsigned W = 8,
	parameter int unsigned N = 9,
	parameter logic [W-1:0] RV = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic         we_i,
	input  wire logic [3:0]   wa_i,
	input  wire logic [W-1:0] wd_i,
	input  wire logic [3:0]   ra_i,
	input  wire logic [3:0]   rb_i,
	output logic      [W-1:0] rda_o,
	output logic      [W-1:0] rdb_o
);
	logic [W-1:0] mem_q [N];
	logic [W-1:0] mem_d [N];
	logic [W-1:0] rda_d;
	logic [W-1:0] rdb_d;

	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			mem_d[i] = (we_i && wa_i == 4'(i)) ? wd_i : mem_q[i];
		end
		rda_d = (int'(ra_i) < N) ? mem_q[ra_i] : '0;
		rdb_d = (int'(rb_i) < N) ? mem_q[rb_i] : '0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < N; i++)
			begin
				mem_q[i] <= RV;
			end
			rda_o <= '0;
			rdb_o <= '0;
		end
		else if (ce_i)
		begin
			mem_q <= mem_d;
			rda_o <= rda_d;
			rdb_o <= rdb_d;
		end
	end
endmodule

// ---- hdl/sac_sar_engine.sv ----
// Successive-approximation engine: sampling aperture then twelve bit trials.
`timescale 1ns/1ps
module sac_sar_engine (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        tick_i,
	input  wire logic        go_i,
	input  wire logic        abort_i,
	input  wire logic [7:0]  samp_i,
	input  wire logic        cmp_i,
	output logic             sample_o,
	output logic      [11:0] dac_o,
	output logic      [11:0] res_o,
	output logic             done_o,
	output logic             busy_o
);
	logic        sample_d;
	logic [11:0] dac_d;
	logic [11:0] res_d;
	logic        done_d;
	logic        busy_d;
	logic [7:0]  cnt_q;
	logic [7:0]  cnt_d;
	logic [3:0]  bit_q;
	logic [3:0]  bit_d;
	logic [11:0] keep;
	logic [8:0]  tcnt_q;
	logic [8:0]  tcnt_d;
	logic [7:0]  slen_q;
	logic [7:0]  slen_d;

	always_comb
	begin
		sample_d = sample_o;
		dac_d    = dac_o;
		res_d    = res_o;
		done_d   = 1'b0;
		busy_d   = busy_o;
		cnt_d    = cnt_q;
		bit_d    = bit_q;
		tcnt_d   = tcnt_q;
		slen_d   = slen_q;
		keep     = cmp_i ? dac_o : (dac_o & ~(12'h001 << bit_q));
		if (abort_i)
		begin
			sample_d = 1'b0;
			busy_d   = 1'b0;
			dac_d    = '0;
		end
		else if (!busy_o && go_i)
		begin
			busy_d   = 1'b1;
			sample_d = 1'b1;
			cnt_d    = (samp_i < sac_pkg::SAMP_MIN) ? sac_pkg::SAMP_MIN : samp_i;
			slen_d   = cnt_d;
			tcnt_d   = '0;
		end
		else if (busy_o && tick_i)
		begin
			tcnt_d = tcnt_q + 9'd1;
			if (sample_o)
			begin
				if (cnt_q == 8'h01)
				begin
					sample_d = 1'b0;
					dac_d    = sac_pkg::DAC_MSB;
					bit_d    = 4'(sac_pkg::BITS - 1);
				end
				else
				begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			else if (bit_q == 4'h0)
			begin
				res_d  = keep;
				dac_d  = keep;
				done_d = 1'b1;
				busy_d = 1'b0;
			end
			else
			begin
				dac_d = keep | (12'h001 << (bit_q - 4'h1));
				bit_d = bit_q - 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sample_o <= 1'b0;
			dac_o    <= '0;
			res_o    <= '0;
			done_o   <= 1'b0;
			busy_o   <= 1'b0;
			cnt_q    <= '0;
			bit_q    <= '0;
			tcnt_q   <= '0;
			slen_q   <= '0;
		end
		else if (ce_i)
		begin
			sample_o <= sample_d;
			dac_o    <= dac_d;
			res_o    <= res_d;
			done_o   <= done_d;
			busy_o   <= busy_d;
			cnt_q    <= cnt_d;
			bit_q    <= bit_d;
			tcnt_q   <= tcnt_d;
			slen_q   <= slen_d;
		end
	end

	conv_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
		done_o |-> tcnt_q >= 9'(sac_pkg::CONV_MIN))
		else $error("Conversion finished in fewer than 18 converter clocks.");
	samp_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		done_o |-> tcnt_q == 9'(slen_q) + 9'(sac_pkg::BITS))
		else $error("Conversion length does not match the programmed sample time.");
endmodule

// ---- hdl/sac_top.sv ----
// Channel sequencer with Wishbone registers for a 12-bit converter.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module sac_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        cmp_i,
	input  wire logic        lowpwr_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	output logic             aclk_o,
	output logic             sample_o,
	output logic      [11:0] dac_o,
	output logic      [3:0]  chan_sel_o,
	output logic      [1:0]  ref_sel_o,
	output logic             busy_o
);
	localparam int unsigned N = sac_pkg::NCH;

	logic               pend_q, pend_d, ack_d;
	logic [31:0]        dat_d, m, wd;
	logic               acc, wr;
	logic               hit_samp, hit_res;
	logic [3:0]         idx;
	logic [9:0]         ctrl_q, ctrl_d;
	logic               start_q, start_d;
	logic [N-1:0]       chen_q, chen_d;
	logic [2:0]         stat_q, stat_d, st_set, st_clr;
	logic [2:0]         mask_q, mask_d;
	logic [31:0]        lim_q, lim_d;
	logic [7:0]         div_q, div_d, div_eff;
	logic [7:0]         dcnt_q, dcnt_d;
	logic               aclk_d, etick_q;
	logic               cs1_q, cs2_q;
	logic               irq_d;
	sac_pkg::sac_state_t st_q, st_d;
	logic [3:0]         cur_q, cur_d, nxt_q, nxt_d;
	logic               last_q, last_d;
	logic [4:0]         pk, f0;
	logic               go, any, oor, done_c;
	logic [7:0]         samp_bus, samp_seq;
	logic [11:0]        res_bus, eng_res;
	logic               eng_done, eng_busy;

	// Lowest enabled channel above c, or the first enabled one with bit 4 set on wrap.
	function automatic logic [4:0] pick(input logic [3:0] c, input logic [N-1:0] en);
		logic [4:0] r;
		logic [4:0] f;
		r = 5'h10;
		f = 5'h10;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (en[i] && 4'(i) > c)
			begin
				r = {1'b0, 4'(i)};
			end
			if (en[i])
			begin
				f = {1'b1, 4'(i)};
			end
		end
		return r[4] ? f : r;
	endfunction

	sac_mem #(
		.W  (8),
		.N  (N),
		.RV (sac_pkg::SAMP_RST)
	) u_samp (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.we_i  (wr && hit_samp && wb_sel_i[0]),
		.wa_i  (idx),
		.wd_i  (wb_dat_i[7:0]),
		.ra_i  (idx),
		.rb_i  (nxt_q),
		.rda_o (samp_bus),
		.rdb_o (samp_seq)
	);

	sac_mem #(
		.W  (12),
		.N  (N),
		.RV (12'h000)
	) u_res (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.we_i  (done_c),
		.wa_i  (cur_q),
		.wd_i  (eng_res),
		.ra_i  (idx),
		.rb_i  (4'h0),
		.rda_o (res_bus),
		.rdb_o ()
	);

	sac_sar_engine u_eng (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.ce_i     (ce_i),
		.tick_i   (etick_q),
		.go_i     (go),
		.abort_i  (lowpwr_i),
		.samp_i   (samp_seq),
		.cmp_i    (cs2_q),
		.sample_o (sample_o),
		.dac_o    (dac_o),
		.res_o    (eng_res),
		.done_o   (eng_done),
		.busy_o   (eng_busy)
	);

	always_comb
	begin
		acc      = wb_cyc_i && wb_stb_i;
		m        = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		wd       = wb_dat_i & m;
		idx      = wb_adr_i[5:2];
		hit_samp = ((wb_adr_i & sac_pkg::REGION_M) == sac_pkg::SAMP_BASE) && int'(idx) < N;
		hit_res  = ((wb_adr_i & sac_pkg::REGION_M) == sac_pkg::RES_BASE) && int'(idx) < N;
		pend_d   = acc && !pend_q && !wb_ack_o;
		ack_d    = acc && pend_q;
		wr       = ack_d && wb_we_i;
		dat_d    = '0;
		ctrl_d   = ctrl_q;
		start_d  = 1'b0;
		chen_d   = chen_q;
		mask_d   = mask_q;
		lim_d    = lim_q;
		div_d    = div_q;
		st_clr   = '0;
		if (wb_adr_i == sac_pkg::CTRL_OFF)
		begin
			dat_d = {22'h0, ctrl_q};
			if (wr)
			begin
				ctrl_d  = (ctrl_q & ~m[9:0]) | (wd[9:0] & ~10'h001);
				start_d = wd[sac_pkg::CTRL_START];
			end
		end
		else if (wb_adr_i == sac_pkg::CHEN_OFF)
		begin
			dat_d = 32'(chen_q);
			if (wr)
			begin
				chen_d = (chen_q & ~m[N-1:0]) | wd[N-1:0];
			end
		end
		else if (wb_adr_i == sac_pkg::STAT_OFF)
		begin
			dat_d = 32'(stat_q) | (32'(eng_busy) << sac_pkg::ST_BUSY)
				| (32'(cur_q) << sac_pkg::ST_CUR);
			if (wr)
			begin
				st_clr = wd[2:0];
			end
		end
		else if (wb_adr_i == sac_pkg::MASK_OFF)
		begin
			dat_d = 32'(mask_q);
			if (wr)
			begin
				mask_d = (mask_q & ~m[2:0]) | wd[2:0];
			end
		end
		else if (wb_adr_i == sac_pkg::LIM_OFF)
		begin
			dat_d = lim_q;
			if (wr)
			begin
				lim_d = ((lim_q & ~m) | wd) & sac_pkg::LIM_MASK;
			end
		end
		else if (wb_adr_i == sac_pkg::DIV_OFF)
		begin
			dat_d = 32'(div_q);
			if (wr)
			begin
				div_d = (div_q & ~m[7:0]) | wd[7:0];
			end
		end
		else if (hit_samp)
		begin
			dat_d = 32'(samp_bus);
		end
		else if (hit_res)
		begin
			dat_d = 32'(res_bus);
		end
	end

	always_comb
	begin
		div_eff = (div_q < sac_pkg::DIV_MIN) ? sac_pkg::DIV_MIN : div_q;
		aclk_d  = 1'b0;
		dcnt_d  = dcnt_q + 8'h01;
		if (dcnt_q >= div_eff - 8'h01)
		begin
			dcnt_d = '0;
			aclk_d = !lowpwr_i;
		end
		any    = ctrl_q[sac_pkg::CTRL_MAN] || (|chen_q);
		pk     = pick(cur_q, chen_q);
		f0     = pick(4'hf, chen_q);
		done_c = (st_q == sac_pkg::SAC_CONV) && eng_done;
		oor    = (eng_res < lim_q[11:0]) || (eng_res > lim_q[27:16]);
		st_d   = st_q;
		cur_d  = cur_q;
		go     = 1'b0;
		st_set = '0;
		nxt_d  = ctrl_q[sac_pkg::CTRL_MAN] ? ctrl_q[sac_pkg::CTRL_MCH +: 4] : f0[3:0];
		last_d = ctrl_q[sac_pkg::CTRL_MAN] || pk[4];
		if (st_q == sac_pkg::SAC_CONV && !ctrl_q[sac_pkg::CTRL_MAN])
		begin
			nxt_d = pk[3:0];
		end
		case (st_q)
			sac_pkg::SAC_IDLE:
			begin
				if (start_q && any)
				begin
					st_d = sac_pkg::SAC_LOAD;
				end
			end
			sac_pkg::SAC_LOAD:
			begin
				st_d = sac_pkg::SAC_PREP;
			end
			sac_pkg::SAC_PREP:
			begin
				go    = 1'b1;
				cur_d = nxt_q;
				st_d  = sac_pkg::SAC_CONV;
			end
			default:
			begin
				if (eng_done)
				begin
					st_set[sac_pkg::ST_CONV] = 1'b1;
					st_set[sac_pkg::ST_OOR]  = oor;
					st_set[sac_pkg::ST_SCAN] = last_q;
					if (any && (!last_q || (ctrl_q[sac_pkg::CTRL_CONT]
						&& !ctrl_q[sac_pkg::CTRL_MAN])))
					begin
						go    = 1'b1;
						cur_d = nxt_q;
					end
					else
					begin
						st_d = sac_pkg::SAC_IDLE;
					end
				end
			end
		endcase
		if (lowpwr_i)
		begin
			st_d = sac_pkg::SAC_IDLE;
			go   = 1'b0;
		end
		stat_d = (stat_q & ~st_clr) | st_set;
		irq_d  = |(stat_q & mask_q);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pend_q   <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			ctrl_q   <= sac_pkg::CTRL_RST;
			start_q  <= 1'b0;
			chen_q   <= '0;
			stat_q   <= '0;
			mask_q   <= '0;
			lim_q    <= sac_pkg::LIM_RST;
			div_q    <= sac_pkg::DIV_RST;
			dcnt_q   <= '0;
			aclk_o   <= 1'b0;
			etick_q  <= 1'b0;
			cs1_q    <= 1'b0;
			cs2_q    <= 1'b0;
			irq_o    <= 1'b0;
			st_q     <= sac_pkg::SAC_IDLE;
			cur_q    <= '0;
			nxt_q    <= '0;
			last_q   <= 1'b0;
		end
		else if (ce_i)
		begin
			pend_q   <= pend_d;
			wb_ack_o <= ack_d;
			wb_dat_o <= ack_d ? dat_d : '0;
			ctrl_q   <= ctrl_d;
			start_q  <= start_d;
			chen_q   <= chen_d;
			stat_q   <= stat_d;
			mask_q   <= mask_d;
			lim_q    <= lim_d;
			div_q    <= div_d;
			dcnt_q   <= dcnt_d;
			aclk_o   <= aclk_d;
			etick_q  <= aclk_o;
			cs1_q    <= cmp_i;
			cs2_q    <= cs1_q;
			irq_o    <= irq_d;
			st_q     <= st_d;
			cur_q    <= cur_d;
			nxt_q    <= nxt_d;
			last_q   <= last_d;
		end
	end

	assign chan_sel_o = cur_q;
	assign ref_sel_o  = ctrl_q[sac_pkg::CTRL_REF +: 2];
	assign busy_o     = eng_busy;

	div_floor_a: assert property (@(posedge clk_i) disable iff (rst_i)
		aclk_o |-> !aclk_d && !$past(aclk_o) && dcnt_q <= 8'h01)
		else $error("Converter clock strobes closer than the floor allows.");
	ref_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr && wb_adr_i == sac_pkg::CTRL_OFF && wb_sel_i[1])
		|=> ref_sel_o == $past(wb_dat_i[9:8]))
		else $error("Reference select did not follow the control write.");
	chan_rng_a: assert property (@(posedge clk_i) disable iff (rst_i)
		int'(chan_sel_o) < N)
		else $error("Channel select outside the channel range.");
	no_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && done_c && !last_q && !lowpwr_i) |=> eng_busy && sample_o)
		else $error("Idle gap between two channels of a scan.");
	man_ch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && st_q == sac_pkg::SAC_PREP && ctrl_q[sac_pkg::CTRL_MAN] && !lowpwr_i)
		|=> chan_sel_o == $past(ctrl_q[sac_pkg::CTRL_MCH +: 4]))
		else $error("Manual conversion used the wrong channel.");
	oor_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && done_c && oor) |=> stat_q[sac_pkg::ST_OOR] ##1 (irq_o || !mask_q[1]))
		else $error("Out-of-range result did not set its flag.");
	lowpwr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && lowpwr_i) |=> st_q == sac_pkg::SAC_IDLE && !sample_o && !aclk_o)
		else $error("Sequencer still active in low-power mode.");
	scan_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && done_c && last_q) |=> stat_q[sac_pkg::ST_SCAN])
		else $error("Scan end did not set the scan-done flag.");
endmodule

// ---- testbench/sac_analog_model.sv ----
// Behavioural model of the analog inputs and the comparator in front of the converter.
`timescale 1ns/1ps
module sac_analog_model #(
	parameter logic [11:0] VIN [0:8] = '{default: 12'h000}
) (
	input  wire logic [3:0]  chan_sel_i,
	input  wire logic [11:0] dac_i,
	output logic             cmp_o
);
	// Eight fixed pin levels, then the temperature sensor on input eight.
	assign cmp_o = (chan_sel_i <= 4'h8) ? (VIN[chan_sel_i] >= dac_i) : 1'b0;
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking testbench for the converter channel sequencer.
`timescale 1ns/1ps
`define CHK(a, e) \
begin \
	num_checks++; \
	if ((a) !== (e)) \
	begin \
		miscompares++; \
		$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); \
	end \
end
module tb_top;
	localparam logic [11:0] VIN [0:8] = '{12'hf12, 12'h111, 12'h5a3, 12'h321, 12'h222,
		12'h333, 12'h444, 12'h555, 12'h7c4};
	logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, cmp_i, lowpwr_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic        wb_ack_o, irq_o, aclk_o, sample_o, busy_o, smp_l;
	logic [11:0] dac_o;
	logic [3:0]  chan_sel_o;
	logic [1:0]  ref_sel_o;
	int          miscompares, num_checks, cyc_n, last_ac, n_ac, aclk_chk;
	int          rise_q[$], wid_q[$];
	logic [3:0]  ch_q[$];
	sac_top u_sac_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .cmp_i(cmp_i), .lowpwr_i(lowpwr_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .irq_o(irq_o), .aclk_o(aclk_o), .sample_o(sample_o),
		.dac_o(dac_o), .chan_sel_o(chan_sel_o), .ref_sel_o(ref_sel_o), .busy_o(busy_o));
	sac_analog_model #(.VIN(VIN)) u_sac_analog_model (.chan_sel_i(chan_sel_o),
		.dac_i(dac_o), .cmp_o(cmp_i));
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Records sampling apertures and converter clock spacing.
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (sample_o && !smp_l)
		begin
			rise_q.push_back(cyc_n);
			ch_q.push_back(chan_sel_o);
		end
		if (!sample_o && smp_l && rise_q.size() > 0)
			wid_q.push_back(cyc_n - rise_q[$]);
		smp_l = sample_o;
		if (aclk_o)
		begin
			n_ac++;
			if (aclk_chk && last_ac >= 0)
				`CHK(cyc_n - last_ac, 6)
			last_ac = cyc_n;
		end
	end
	task automatic complete_run;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic poll(input int b);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, sac_pkg::STAT_OFF, 32'h0);
			n++;
		end
		while (q[b] !== 1'b1 && n < 500);
		if (n >= 500)
			miscompares++;
	endtask
	task automatic test_reset;
		logic [7:0]  adr [0:8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h40, 8'h80, 8'h20};
		logic [31:0] exp [0:8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0fff_0000, 32'h6, 32'h6,
			32'h0, 32'h0};
		wr(sac_pkg::RES_BASE, 32'h0000_0abc);
		for (int i = 0; i < 9; i++)
		begin
			bus(1'b0, adr[i], 32'h0);
			`CHK(q, exp[i])
		end
		`CHK(ref_sel_o, 2'h0)
	endtask
	task automatic test_ref;
		for (int r = 0; r < 4; r++)
		begin
			wr(sac_pkg::CTRL_OFF, 32'(r) << 8);
			`CHK(ref_sel_o, 2'(r))
		end
		wr(sac_pkg::CTRL_OFF, 32'h0);
	endtask
	task automatic test_scan;
		logic [3:0] ech [0:2] = '{4'h0, 4'h2, 4'h8};
		int         ew [0:2] = '{36, 53, 35};
		wr(sac_pkg::LIM_OFF, 32'h0e00_0100);
		wr(sac_pkg::DIV_OFF, 32'h2);
		wr(sac_pkg::SAMP_BASE, 32'h2);
		wr(sac_pkg::SAMP_BASE + 8'h08, 32'h9);
		wr(sac_pkg::CHEN_OFF, 32'h105);
		ch_q.delete();
		rise_q.delete();
		wid_q.delete();
		wr(sac_pkg::CTRL_OFF, 32'h1);
		poll(0);
		`CHK(q[2:1], 2'b01)
		poll(2);
		`CHK(q & 32'h107, 32'h7)
		`CHK(ch_q.size(), 3)
		for (int i = 0; i < 3; i++)
		begin
			`CHK(ch_q[i], ech[i])
			`CHK(wid_q[i], ew[i])
			bus(1'b0, sac_pkg::RES_BASE + {2'b00, ech[i], 2'b00}, 32'h0);
			`CHK(q, {20'h0, VIN[ech[i]]})
		end
		`CHK(rise_q[1] - rise_q[0], 109)
		`CHK(rise_q[2] - rise_q[1], 126)
	endtask
	task automatic test_irq;
		wr(sac_pkg::MASK_OFF, 32'h7);
		@(posedge clk_i);
		`CHK(irq_o, 1'b1)
		wr(sac_pkg::MASK_OFF, 32'h0);
		bus(1'b0, sac_pkg::MASK_OFF, 32'h0);
		`CHK(irq_o, 1'b0)
		wr(sac_pkg::MASK_OFF, 32'h2);
		@(posedge clk_i);
		`CHK(irq_o, 1'b1)
		wr(sac_pkg::STAT_OFF, 32'h2);
		bus(1'b0, sac_pkg::STAT_OFF, 32'h0);
		`CHK(q[2:0], 3'b101)
		`CHK(irq_o, 1'b0)
		wr(sac_pkg::STAT_OFF, 32'h7);
	endtask
	task automatic test_manual;
		ch_q.delete();
		wr(sac_pkg::CTRL_OFF, 32'h35);
		poll(0);
		`CHK(q[2], 1'b1)
		`CHK(ch_q[0], 4'h3)
		bus(1'b0, sac_pkg::RES_BASE + 8'h0c, 32'h0);
		`CHK(q, {20'h0, VIN[3]})
		wr(sac_pkg::CTRL_OFF, 32'h0);
		wr(sac_pkg::STAT_OFF, 32'h7);
	endtask
	task automatic test_lowpwr;
		wr(sac_pkg::CTRL_OFF, 32'h3);
		repeat (40) @(posedge clk_i);
		lowpwr_i <= 1'b1;
		aclk_chk = 0;
		repeat (4) @(posedge clk_i);
		n_ac = 0;
		repeat (30) @(posedge clk_i);
		`CHK(n_ac, 0)
		`CHK(busy_o, 1'b0)
		wr(sac_pkg::CTRL_OFF, 32'h0);
		lowpwr_i <= 1'b0;
		last_ac = -1;
		aclk_chk = 1;
		repeat (100) @(posedge clk_i);
		`CHK(busy_o, 1'b0)
	endtask
	initial
	begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		lowpwr_i = 1'b0;
		smp_l = 1'b0;
		last_ac = -1;
		aclk_chk = 1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset();
		test_ref();
		test_scan();
		test_irq();
		test_manual();
		test_lowpwr();
		complete_run();
	end
	initial
	begin
		#200000;
		miscompares++;
		complete_run();
	end
endmodule
